/* File: sfm_pkg.sv */
`default_nettype none
// Shared constants and carriers for the section filter match engine.
package sfm_pkg;

  // Table geometry and search length.
  localparam int SFM_ENTRIES = 32;
  localparam int SFM_IDX_W = 5;
  localparam int SFM_FIRST_W = 7;
  localparam int SFM_DATA_BYTES = 8;
  localparam int SFM_ADDR_W = 11;
  localparam int SFM_BE_W = 4;
  localparam logic [4:0] SFM_SCAN_LAST = 5'h1F;

  // Register byte offsets; the low two address bits are ignored.
  localparam logic [10:0] SFM_OFS_CTRL = 11'h000;
  localparam logic [10:0] SFM_OFS_STATUS = 11'h004;
  localparam logic [10:0] SFM_OFS_HITS = 11'h008;
  localparam logic [10:0] SFM_OFS_KEY_DATA = 11'h00C;
  localparam logic [10:0] SFM_OFS_KEY_ATTR = 11'h010;
  localparam logic [10:0] SFM_FILT_BASE = 11'h200;
  localparam logic [10:0] SFM_FILT_SPAN = 11'h200;
  localparam logic [10:0] SFM_MASK_BASE = 11'h400;
  localparam logic [10:0] SFM_MASK_SPAN = 11'h100;

  // Entry strides and word selectors inside one entry.
  localparam int SFM_FILT_SHIFT = 4;
  localparam int SFM_MASK_SHIFT = 3;
  localparam int SFM_WORD_LSB = 2;
  localparam logic [1:0] SFM_FW_HI = 2'h0;
  localparam logic [1:0] SFM_FW_LO = 2'h1;
  localparam logic [1:0] SFM_FW_ATTR = 2'h2;

  // Control and status bit positions.
  localparam int SFM_CTRL_INIT = 0;
  localparam int SFM_ST_DONE = 0;
  localparam int SFM_ST_FOUND = 1;
  localparam int SFM_ST_IDX_LSB = 25;

  typedef enum logic [1:0] {SFM_IDLE = 2'h1, SFM_SCAN = 2'h2} sfm_fsm_t;

  // Layout shared by the filter attribute and the search key attribute.
  typedef struct packed {
    logic [15:0] diff;
    logic [7:0] key_byte;
    logic spare;
    logic en;
    logic [5:0] pid;
  } sfm_attr_t;

  // Every piece of engine state, registered as one word.
  typedef struct packed {
    logic [SFM_ENTRIES-1:0][31:0] filt_hi;
    logic [SFM_ENTRIES-1:0][31:0] filt_lo;
    logic [SFM_ENTRIES-1:0][31:0] filt_attr;
    logic [SFM_ENTRIES-1:0][31:0] mask_hi;
    logic [SFM_ENTRIES-1:0][31:0] mask_lo;
    logic [1:0][31:0] key_hi;
    logic [1:0][31:0] key_lo;
    logic [1:0][31:0] key_attr;
    logic load_sel;
    logic act_sel;
    logic key_word;
    sfm_fsm_t state;
    logic [SFM_IDX_W-1:0] idx;
    logic [SFM_ENTRIES-1:0] hits;
    logic done;
    logic found;
    logic [SFM_FIRST_W-1:0] first;
    logic [31:0] rdata;
    logic wait_r;
  } sfm_regs_t;

endpackage
`default_nettype wire

/* File: sfm_engine.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
// Contract
// (R01) Thirty-two entries, each with filter, mask and attribute at one index.
// (R02) A search takes 32 cycles; result visible in the next cycle.
// (R03) Entry words: 0 high data, 1 low data, 2 attribute, 3 unused.
// (R04) Attribute bits 5..0 hold the stream id slot of the entry.
// (R05) Attribute bit 6 enables the entry; disabled entries never match.
// (R06) Attribute bits 15..8 compare unmasked with key attribute bits 15..8.
// (R07) Attribute bits 31..16 select per-byte difference matching, bit 16+n byte n.
// (R08) Mask is applied to filter and key data; one bits count.
// (R09) Two key data sets alternate; attribute write flips loading to other set.
// (R10) Writing the key attribute starts a search; software writes it last.
// (R11) Software writes key attribute with slot, search byte and zero spares.
// (R12) Match needs enable, equal slot and equal masked data.
// (R13) Software starts no new search until done is set.
// (R14) Hit vector holds one bit per entry; several may be set.
// (R15) Done clears when a search starts and sets when it completes.
// (R16) Found sets when any hit bit is set.
// (R17) Status bits 31..25 give first match index; bits 24..2 read zero.
// (R18) Writing one to control bit 0 initialises the engine.
// (R19) Software loads key data high word, then low word, before attribute.
// (R20) With several matches the lowest matching entry index is reported.
// (R21) Results and status hold until the next search or initialisation.
module sfm_engine
  import sfm_pkg::*;
(
  input wire logic clk, // System clock, 250 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [SFM_ADDR_W-1:0] avs_address, // Byte address of the word.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [SFM_BE_W-1:0] avs_byteenable, // Byte lanes of a write.
  output logic [31:0] avs_readdata, // Read data, registered.
  output logic avs_waitrequest // Stall, registered; idles high.
);

  sfm_regs_t st_r;
  sfm_regs_t st_nxt;

  logic req;
  logic acc;
  logic wr_acc;
  logic in_filt;
  logic in_mask;
  logic [SFM_ADDR_W-1:0] fofs;
  logic [SFM_ADDR_W-1:0] mofs;
  logic [SFM_IDX_W-1:0] fent;
  logic [SFM_IDX_W-1:0] ment;
  logic [1:0] fwd;
  logic start_go;
  logic init_go;
  logic hit_now;
  logic [31:0] rd_val;
  logic [63:0] act_key;
  logic [SFM_ENTRIES-1:0] en_vec;

  // Word-level register select; byte offsets inside a word are ignored.
  function automatic logic reg_is(logic [SFM_ADDR_W-1:0] a, logic [SFM_ADDR_W-1:0] ofs);
    return a[SFM_ADDR_W-1:SFM_WORD_LSB] == ofs[SFM_ADDR_W-1:SFM_WORD_LSB];
  endfunction

  // True when the address falls inside a table window.
  function automatic logic in_win(logic [SFM_ADDR_W-1:0] a, logic [SFM_ADDR_W-1:0] base,
                                  logic [SFM_ADDR_W-1:0] span);
    return (a >= base) && (a < base + span);
  endfunction

  // Lane-wise merge so that partial writes leave other bytes intact.
  function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] nw,
                                           logic [SFM_BE_W-1:0] be);
    logic [31:0] r;
    r = old;
    for (int l = 0; l < SFM_BE_W; l++) begin
      if (be[l]) begin
        r[l*8 +: 8] = nw[l*8 +: 8];
      end
    end
    return r;
  endfunction

  // Status word as software sees it; unused bits read as zero.
  function automatic logic [31:0] status_word(logic done, logic found,
                                              logic [SFM_FIRST_W-1:0] first);
    logic [31:0] w;
    w = '0;
    w[SFM_ST_DONE] = done; // R15
    w[SFM_ST_FOUND] = found; // R16
    w[SFM_ST_IDX_LSB +: SFM_FIRST_W] = first; // R17
    return w;
  endfunction

  // Compares one entry against the active search key.
  // The mask gates both sides first, so a zero mask bit never decides an equal byte; a difference byte whose mask is all zero never matches.
  function automatic logic entry_hit(sfm_attr_t fa, logic [63:0] fd, logic [63:0] m,
                                     sfm_attr_t ka, logic [63:0] kd);
    logic ok;
    logic [7:0] fb;
    logic [7:0] kb;
    ok = fa.en; // R05
    ok = ok && (fa.pid == ka.pid); // R04
    ok = ok && (fa.key_byte == ka.key_byte); // R06
    for (int b = 0; b < SFM_DATA_BYTES; b++) begin
      fb = fd[b*8 +: 8] & m[b*8 +: 8]; // R08
      kb = kd[b*8 +: 8] & m[b*8 +: 8]; // R08
      if (fa.diff[b]) begin
        ok = ok && (fb != kb); // R07
      end else begin
        ok = ok && (fb == kb); // R12
      end
    end
    return ok;
  endfunction

  // Enable bits of all entries, read only by the checks below.
  // Each word is viewed through the attribute layout before its enable bit is taken.
  always_comb begin
    sfm_attr_t fa;
    fa = '0;
    for (int i = 0; i < SFM_ENTRIES; i++) begin
      fa = sfm_attr_t'(st_r.filt_attr[i]);
      en_vec[i] = fa.en; // R05
    end
  end

  // Next-state logic: bus slave, key loading, the scan and initialisation.
  always_comb begin
    st_nxt = st_r;
    req = avs_read | avs_write;
    acc = req & ~st_r.wait_r;
    wr_acc = acc & avs_write;
    in_filt = in_win(avs_address, SFM_FILT_BASE, SFM_FILT_SPAN);
    in_mask = in_win(avs_address, SFM_MASK_BASE, SFM_MASK_SPAN);
    fofs = avs_address - SFM_FILT_BASE;
    mofs = avs_address - SFM_MASK_BASE;
    fent = fofs[SFM_FILT_SHIFT +: SFM_IDX_W]; // R01
    ment = mofs[SFM_MASK_SHIFT +: SFM_IDX_W]; // R01
    fwd = avs_address[SFM_WORD_LSB +: 2];
    start_go = wr_acc && reg_is(avs_address, SFM_OFS_KEY_ATTR)
               && (st_r.state == SFM_IDLE); // R10
    init_go = wr_acc && reg_is(avs_address, SFM_OFS_CTRL)
              && avs_writedata[SFM_CTRL_INIT]; // R18
    act_key = {st_r.key_hi[st_r.act_sel], st_r.key_lo[st_r.act_sel]};
    hit_now = entry_hit(sfm_attr_t'(st_r.filt_attr[st_r.idx]),
                        {st_r.filt_hi[st_r.idx], st_r.filt_lo[st_r.idx]},
                        {st_r.mask_hi[st_r.idx], st_r.mask_lo[st_r.idx]},
                        sfm_attr_t'(st_r.key_attr[st_r.act_sel]), act_key); // R12

    // Read multiplexer; write-only and unmapped words read as zero.
    rd_val = '0;
    if (in_filt) begin
      case (fwd)
        SFM_FW_HI: rd_val = st_r.filt_hi[fent]; // R03
        SFM_FW_LO: rd_val = st_r.filt_lo[fent]; // R03
        SFM_FW_ATTR: rd_val = st_r.filt_attr[fent]; // R03
        default: rd_val = '0;
      endcase
    end else if (in_mask) begin
      rd_val = avs_address[SFM_WORD_LSB] ? st_r.mask_lo[ment] : st_r.mask_hi[ment];
    end else if (reg_is(avs_address, SFM_OFS_STATUS)) begin
      rd_val = status_word(st_r.done, st_r.found, st_r.first);
    end else if (reg_is(avs_address, SFM_OFS_HITS)) begin
      rd_val = st_r.hits; // R14
    end

    // Every request waits exactly one cycle, which gives the mux a full cycle.
    st_nxt.wait_r = ~(req & st_r.wait_r);
    if (req && st_r.wait_r) begin
      st_nxt.rdata = avs_read ? rd_val : '0;
    end

    // One entry per cycle, lowest index first, so the first hit is the lowest.
    case (st_r.state)
      SFM_SCAN: begin
        if (hit_now) begin
          st_nxt.hits[st_r.idx] = 1'b1; // R14
          if (!st_r.found) begin
            st_nxt.found = 1'b1; // R16
            st_nxt.first = SFM_FIRST_W'(st_r.idx); // R20
          end
        end
        st_nxt.idx = st_r.idx + 5'h1;
        if (st_r.idx == SFM_SCAN_LAST) begin
          st_nxt.state = SFM_IDLE;
          st_nxt.done = 1'b1; // R02
        end
      end
      SFM_IDLE: begin
        st_nxt.idx = '0;
      end
      default: begin
        st_nxt.state = SFM_IDLE;
      end
    endcase

    // Register writes take effect only on the cycle the request is accepted.
    if (wr_acc) begin
      if (in_filt) begin
        case (fwd)
          SFM_FW_HI: st_nxt.filt_hi[fent] =
            be_merge(st_r.filt_hi[fent], avs_writedata, avs_byteenable); // R03
          SFM_FW_LO: st_nxt.filt_lo[fent] =
            be_merge(st_r.filt_lo[fent], avs_writedata, avs_byteenable); // R03
          SFM_FW_ATTR: st_nxt.filt_attr[fent] =
            be_merge(st_r.filt_attr[fent], avs_writedata, avs_byteenable); // R03
          default: st_nxt.idx = st_nxt.idx;
        endcase
      end else if (in_mask) begin
        if (avs_address[SFM_WORD_LSB]) begin
          st_nxt.mask_lo[ment] = be_merge(st_r.mask_lo[ment], avs_writedata, avs_byteenable);
        end else begin
          st_nxt.mask_hi[ment] = be_merge(st_r.mask_hi[ment], avs_writedata, avs_byteenable);
        end
      end else if (reg_is(avs_address, SFM_OFS_KEY_DATA)) begin
        // High word first, then low word, into the set not under search.
        if (!st_r.key_word) begin
          st_nxt.key_hi[st_r.load_sel] =
            be_merge(st_r.key_hi[st_r.load_sel], avs_writedata, avs_byteenable); // R09
        end else begin
          st_nxt.key_lo[st_r.load_sel] =
            be_merge(st_r.key_lo[st_r.load_sel], avs_writedata, avs_byteenable); // R09
        end
        st_nxt.key_word = ~st_r.key_word;
      end
    end

    // A start while busy is dropped whole, so the running key set stays intact.
    if (start_go) begin
      st_nxt.key_attr[st_r.load_sel] =
        be_merge(st_r.key_attr[st_r.load_sel], avs_writedata, avs_byteenable); // R10
      st_nxt.act_sel = st_r.load_sel; // R09
      st_nxt.load_sel = ~st_r.load_sel; // R09
      st_nxt.key_word = 1'b0;
      st_nxt.state = SFM_SCAN;
      st_nxt.idx = '0;
      st_nxt.hits = '0; // R21
      st_nxt.done = 1'b0; // R15
      st_nxt.found = 1'b0; // R21
      st_nxt.first = '0; // R21
    end

    // Initialisation clears the scan, results and key pointers but keeps the tables and both key sets.
    if (init_go) begin
      st_nxt.state = SFM_IDLE; // R18
      st_nxt.idx = '0;
      st_nxt.hits = '0;
      st_nxt.done = 1'b0;
      st_nxt.found = 1'b0;
      st_nxt.first = '0;
      st_nxt.load_sel = 1'b0;
      st_nxt.act_sel = 1'b0;
      st_nxt.key_word = 1'b0;
    end
  end

  // State register; tables clear too, so reads after reset are defined.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.state <= SFM_IDLE;
      st_r.wait_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.wait_r;

  // Checks on the engine's own behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_start;
    start_go;
  endsequence

  sequence s_init;
    init_go;
  endsequence

  // One scan cycle that no initialisation cuts short.
  sequence s_scan_step;
    st_r.state == SFM_SCAN && !init_go;
  endsequence

  // The first hit of the current search is under the scan pointer.
  sequence s_hit_first;
    st_r.state == SFM_SCAN && hit_now && !st_r.found && !init_go;
  endsequence

  sequence s_scan_run;
    ##32 !st_r.done ##1 st_r.done;
  endsequence

  property p_scan_len;
    @(posedge clk) disable iff (!reset_n || init_go)
    s_start |-> s_scan_run;
  endproperty

  scan_length_a: assert property (p_scan_len) // R02
    else $error("search did not finish in 32 cycles");

  done_clear_a: assert property (s_start |=> !st_r.done && st_r.hits == '0) // R15
    else $error("done or hits not cleared at search start");

  key_swap_a: assert property (s_start |=> st_r.load_sel != $past(st_r.load_sel) // R09
                               && st_r.act_sel == $past(st_r.load_sel))
    else $error("key set did not alternate on search start");

  found_flag_a: assert property (st_r.done |-> st_r.found == (st_r.hits != '0)) // R16
    else $error("found bit disagrees with hit vector");

  first_index_a: assert property (st_r.done && st_r.found |-> // R20
      st_r.hits[st_r.first[SFM_IDX_W-1:0]]
      && ((st_r.hits & ((32'h1 << st_r.first[SFM_IDX_W-1:0]) - 32'h1)) == '0))
    else $error("first index is not the lowest hit");

  enable_gate_a: assert property ($rose(st_r.done) |-> (st_r.hits & ~en_vec) == '0) // R05
    else $error("disabled entry reported a hit");

  init_clear_a: assert property (s_init |=> st_r.state == SFM_IDLE // R18
                                 && !st_r.done && st_r.hits == '0)
    else $error("initialisation did not clear the engine");

  result_hold_a: assert property (st_r.done && !start_go && !init_go |=> // R21
      st_r.done && $stable(st_r.hits) && $stable(st_r.first))
    else $error("results changed without a new search");

  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest)
    else $error("bus request not answered in one cycle");

  // An idle bus leaves the slave stalled, so a new request always waits one cycle.
  wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without a pending request");

  // A write answers with zero read data, so stale words never leak onto the bus.
  wr_data_zero_a: assert property (avs_write && avs_waitrequest |=> avs_readdata == '0)
    else $error("write answered with nonzero read data");

  // The pointer walks every entry, so each search costs the same number of cycles.
  scan_step_a: assert property (s_scan_step |=> st_r.idx == $past(st_r.idx) + 5'h1) // R02
    else $error("scan pointer did not advance by one");

  // The active key set must not move while the loader fills the other set.
  busy_drop_a: assert property (s_scan_step |=> $stable(st_r.act_sel) // R09
      && $stable(act_key) && $stable(st_r.key_attr))
    else $error("active key changed during a search");

  // Hits only accumulate until the next start or initialisation.
  hits_grow_a: assert property (s_scan_step |=> // R14
      (st_r.hits & $past(st_r.hits)) == $past(st_r.hits))
    else $error("hit bit lost during a search");

  // The first hit captures the pointer; later hits must leave it alone.
  first_latch_a: assert property (s_hit_first |=> st_r.found // R20
      && st_r.first[SFM_IDX_W-1:0] == $past(st_r.idx))
    else $error("first hit index not captured");

  // Found tracks the hit vector while the scan is still running.
  found_any_a: assert property (st_r.state == SFM_SCAN |-> // R16
      st_r.found == (st_r.hits != '0))
    else $error("found bit disagrees with hits during a search");

  // Done is only ever shown once the scan has stopped.
  done_idle_a: assert property (st_r.done |-> st_r.state == SFM_IDLE) // R15
    else $error("done shown while the scan still runs");

  // The loader alternates high and low words on every accepted data write.
  key_toggle_a: assert property (wr_acc && reg_is(avs_address, SFM_OFS_KEY_DATA) |=> // R19
      st_r.key_word != $past(st_r.key_word))
    else $error("key word pointer did not toggle");

endmodule
`default_nettype wire

/* File: sfm_host.sv */
`default_nettype none
// Firmware stand-in that masters the register bus of the filter engine.
module sfm_host
  import sfm_pkg::*;
(
  input wire logic clk, // Bus clock.
  output logic [SFM_ADDR_W-1:0] avs_address, // Byte address.
  output logic avs_read, // Read request.
  output logic avs_write, // Write request.
  output logic [31:0] avs_writedata, // Write data.
  output logic [SFM_BE_W-1:0] avs_byteenable, // Byte lanes, always all four.
  input wire logic [31:0] avs_readdata, // Read data.
  input wire logic avs_waitrequest // Stall.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero; firmware only ever moves whole words.
  initial begin
    avs_address = 11'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
  end

  // One transfer; the request stands until waitrequest is sampled low.
  task automatic xfer(input logic is_rd, input logic [10:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_read <= is_rd;
    avs_write <= !is_rd;
    avs_writedata <= d;
    @(posedge clk);
    // Only the bench watchdog ends a wait that never gets an answer.
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [10:0] a, output logic [31:0] q);
    xfer(1'b1, a, 32'h00000000, q);
  endtask

  // Key words go high then low, and the attribute last since it starts the search.
  task automatic search(input logic [31:0] h, l, at);
    wr(SFM_OFS_KEY_DATA, h);
    wr(SFM_OFS_KEY_DATA, l);
    wr(SFM_OFS_KEY_ATTR, at);
  endtask

  // Poll until done before anything may start the next search.
  task automatic wait_done(output logic [31:0] st);
    rd(SFM_OFS_STATUS, st);
    while (st[SFM_ST_DONE] !== 1'b1) begin
      rd(SFM_OFS_STATUS, st);
    end
  endtask
endmodule
`default_nettype wire

/* File: test_section_filter_match_engine.sv */
`default_nettype none
module test_section_filter_match_engine
  import sfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic reset_n;
  logic [SFM_ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [SFM_BE_W-1:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] q;
  int n_errors = 0;
  int checked = 0;

  sfm_engine i_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  sfm_host i_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One entry: filter words, attribute and mask in a single call.
  task automatic put(input int i, input logic [31:0] h, l, at, mh, ml);
    i_host.wr(SFM_FILT_BASE + 11'(i * 16), h);
    i_host.wr(SFM_FILT_BASE + 11'(i * 16 + 4), l);
    i_host.wr(SFM_FILT_BASE + 11'(i * 16 + 8), at);
    i_host.wr(SFM_MASK_BASE + 11'(i * 8), mh);
    i_host.wr(SFM_MASK_BASE + 11'(i * 8 + 4), ml);
  endtask

  // Quiet state after reset, and writes to a hole are lost.
  task automatic t_reset();
    i_host.rd(SFM_OFS_STATUS, q);
    cmp(q, 32'h00000000);
    i_host.rd(SFM_OFS_HITS, q);
    cmp(q, 32'h00000000);
    i_host.wr(11'h020, 32'h12345678);
    i_host.rd(11'h020, q);
    cmp(q, 32'h00000000);
  endtask

  // Entries 5, 11, 12 and 13 each probe one part of the match condition against the first key; 3, 7, 11 and 13 match it, 9 is for the second key.
  task automatic t_table();
    put(3, 32'h11223344, 32'h55667788, 32'h0000A541, 32'hFFFFFFFF, 32'hFFFFFFFF);
    put(7, 32'h11223344, 32'h55667788, 32'h0000A541, 32'hFFFFFFFF, 32'hFFFFFFFF);
    put(5, 32'h11223344, 32'h55667788, 32'h0000A501, 32'hFFFFFFFF, 32'hFFFFFFFF);
    put(9, 32'hCAFE0001, 32'h0BADF00D, 32'h0000A542, 32'hFFFFFFFF, 32'hFFFFFFFF);
    put(11, 32'hFF223344, 32'h55667788, 32'h0000A541, 32'h00FFFFFF, 32'hFFFFFFFF);
    put(12, 32'h11223344, 32'h55667788, 32'h00005A41, 32'hFFFFFFFF, 32'hFFFFFFFF);
    put(13, 32'h11223344, 32'h55667700, 32'h0001A541, 32'hFFFFFFFF, 32'hFFFFFFFF);
    i_host.rd(SFM_FILT_BASE + 11'h038, q);
    cmp(q, 32'h0000A541);
    i_host.wr(SFM_FILT_BASE + 11'h0EC, 32'hDEADBEEF);
    i_host.rd(SFM_FILT_BASE + 11'h0EC, q);
    cmp(q, 32'h00000000);
  endtask

  // First search, with the next key loaded into the idle set while it runs.
  task automatic t_search();
    i_host.search(32'h11223344, 32'h55667788, 32'h0000A501);
    i_host.rd(SFM_OFS_STATUS, q);
    cmp(q & 32'h00000001, 32'h00000000);
    i_host.wr(SFM_OFS_KEY_DATA, 32'hCAFE0001);
    i_host.wr(SFM_OFS_KEY_DATA, 32'h0BADF00D);
    repeat (14) @(posedge clk);
    i_host.rd(SFM_OFS_STATUS, q);
    cmp(q & 32'h00000001, 32'h00000000);
    repeat (10) @(posedge clk);
    i_host.rd(SFM_OFS_STATUS, q);
    cmp(q, 32'h06000003);
    i_host.rd(SFM_OFS_HITS, q);
    cmp(q, 32'h00002888);
  endtask

  // Second search uses the preloaded set; a start while busy is dropped.
  task automatic t_second();
    i_host.wr(SFM_OFS_KEY_ATTR, 32'h0000A502);
    i_host.wr(SFM_OFS_KEY_ATTR, 32'h0000A501);
    i_host.wait_done(q);
    cmp(q, 32'h12000003);
    i_host.rd(SFM_OFS_HITS, q);
    cmp(q, 32'h00000200);
    repeat (20) @(posedge clk);
    i_host.rd(SFM_OFS_HITS, q);
    cmp(q, 32'h00000200);
  endtask

  // Initialise clears results; a search on an empty slot finds nothing.
  task automatic t_init();
    i_host.wr(SFM_OFS_CTRL, 32'h00000001);
    i_host.rd(SFM_OFS_STATUS, q);
    cmp(q, 32'h00000000);
    i_host.rd(SFM_OFS_HITS, q);
    cmp(q, 32'h00000000);
    i_host.search(32'h11223344, 32'h55667788, 32'h0000A505);
    i_host.wait_done(q);
    cmp(q, 32'h00000001);
  endtask

  // Reset, then the scenarios in order.
  initial begin
    reset_n = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_table();
    t_search();
    t_second();
    t_init();
    report_and_stop();
  end

  // A hang is cut off well beyond the expected run of a few hundred cycles.
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
